// ==== rbx_link.sv ====
/*
 Remote binary exchange: sixteen local channel states are framed and sent
 to the peer at a fixed interval; frames from the peer are checked and
 their states driven on sixteen outputs, with failure detection and
 automatic recovery.
 Assumes one 50 MHz clock, synchronous inputs, and a link layer that
 takes whole frames by valid/ready and delivers received frames with a
 valid strobe and a line error flag.
*/
`timescale 1ns/1ps
`default_nettype none

module rbx_link
    import rbx_pkg::*;
#(
    parameter logic [15:0] SEND_PERIOD_CYC = 16'(RBX_SEND_CYC),
    parameter logic [15:0] RX_TIMEOUT_CYC = 16'(RBX_RX_TIMEOUT_CYC),
    parameter logic [7:0] FAIL_COUNT = 8'(RBX_FAIL_COUNT),
    parameter logic [7:0] RECOVER_COUNT = 8'(RBX_RECOVER_COUNT),
    parameter int FIFO_DEPTH = RBX_FIFO_DEPTH
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [RBX_CHANNELS-1:0] tx_chan_in,
    output logic [RBX_CHANNELS-1:0] rx_chan_out,
    output logic link_failure_flag_out,
    output logic link_tx_valid_out,
    output rbx_frame_t link_tx_frame_out,
    input wire logic link_tx_ready_in,
    input wire logic link_rx_valid_in,
    input wire rbx_frame_t link_rx_frame_in,
    input wire logic link_rx_error_in
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    // bad_cnt runs only while running, good_cnt only while failed
    typedef struct packed {
        rbx_state_t st;
        logic [15:0] tick_cnt;
        logic pend;
        logic [15:0] silence_cnt;
        logic [7:0] bad_cnt;
        logic [7:0] good_cnt;
        logic [RBX_CHANNELS-1:0] rx_chan;
    } rbx_core_t;

    rbx_core_t q, d;

    logic tick;
    logic push;
    logic fifo_ready;
    logic good_ev;
    logic bad_ev;
    logic timeout;
    logic fail_due;
    logic recover_due;
    rbx_frame_t tx_frame;

    // complement copy lets the far end spot corrupted channel bits
    function automatic rbx_frame_t make_frame(
        input logic [RBX_CHANNELS-1:0] chan);
        rbx_frame_t f;
        f.chan = chan;
        f.chan_n = ~chan;
        return f;
    endfunction : make_frame

    function automatic logic frame_ok(input rbx_frame_t f);
        frame_ok = (f.chan == ~f.chan_n);
    endfunction : frame_ok

    // ------------------------------------------------------------
    // run counters
    // ------------------------------------------------------------
    // saturating, so a run can never wrap back below its threshold
    function automatic logic [7:0] run_next(input logic [7:0] cnt);
        run_next = (cnt == 8'hFF) ? cnt : cnt + 8'h01;
    endfunction : run_next

    // true when one more frame of the run reaches the threshold
    function automatic logic run_done(input logic [7:0] cnt,
        input logic [7:0] lim);
        run_done = (run_next(cnt) >= lim);
    endfunction : run_done

    // ------------------------------------------------------------
    // send path
    // ------------------------------------------------------------
    assign tick = (q.tick_cnt == SEND_PERIOD_CYC - 16'h0001);
    // ticks that fall while the fifo is full merge into the pending
    // request, so a long stall shows at the far end as a longer gap
    assign push = q.pend & fifo_ready;
    // sampled at the push, so the frame holds the freshest states
    assign tx_frame = make_frame(tx_chan_in);

    rbx_fifo #(
        .WIDTH(RBX_FRAME_W),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .in_valid_in(q.pend),
        .in_data_in(tx_frame),
        .in_ready_out(fifo_ready),
        .out_valid_out(link_tx_valid_out),
        .out_data_out(link_tx_frame_out),
        .out_ready_in(link_tx_ready_in)
    );

    // ------------------------------------------------------------
    // receive checks
    // ------------------------------------------------------------
    // a silent link counts as a bad frame, otherwise a dead fibre
    // would never raise the flag
    assign timeout = !link_rx_valid_in
        && (q.silence_cnt == RX_TIMEOUT_CYC - 16'h0001);
    assign good_ev = link_rx_valid_in && !link_rx_error_in
        && frame_ok(link_rx_frame_in);
    assign bad_ev = (link_rx_valid_in && !good_ev) || timeout;
    // thresholds look one frame ahead, so the state moves on the very
    // frame that completes the run
    assign fail_due = run_done(q.bad_cnt, FAIL_COUNT);
    assign recover_due = run_done(q.good_cnt, RECOVER_COUNT);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        // free-running interval, no request from local logic needed
        if (tick) begin
            d.tick_cnt = 16'h0000;
        end else begin
            d.tick_cnt = q.tick_cnt + 16'h0001;
        end
        // a new tick wins over the clearing push; a stalled fifo keeps
        // the request pending rather than dropping it
        if (push) begin
            d.pend = 1'b0;
        end
        if (tick) begin
            d.pend = 1'b1;
        end
        if (link_rx_valid_in || timeout) begin
            d.silence_cnt = 16'h0000;
        end else begin
            d.silence_cnt = q.silence_cnt + 16'h0001;
        end
        case (q.st)
            RBX_ST_RUN: begin
                if (good_ev) begin
                    d.rx_chan = link_rx_frame_in.chan;
                    d.bad_cnt = 8'h00;
                end else if (bad_ev) begin
                    if (fail_due) begin
                        d.st = RBX_ST_FAIL;
                        d.bad_cnt = 8'h00;
                        d.good_cnt = 8'h00;
                    end else begin
                        d.bad_cnt = run_next(q.bad_cnt);
                    end
                end
            end
            RBX_ST_FAIL: begin
                // outputs frozen at the last valid states here
                if (good_ev) begin
                    if (recover_due) begin
                        d.st = RBX_ST_RUN;
                        d.good_cnt = 8'h00;
                        d.rx_chan = link_rx_frame_in.chan;
                    end else begin
                        d.good_cnt = run_next(q.good_cnt);
                    end
                end else if (bad_ev) begin
                    d.good_cnt = 8'h00;
                end
            end
            default: begin
                d.st = RBX_ST_FAIL;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            q.st <= RBX_ST_RUN;
            q.tick_cnt <= 16'h0000;
            q.pend <= 1'b0;
            q.silence_cnt <= 16'h0000;
            q.bad_cnt <= 8'h00;
            q.good_cnt <= 8'h00;
            q.rx_chan <= RBX_CHAN_RST;
        end else begin
            q <= d;
        end
    end

    assign rx_chan_out = q.rx_chan;
    assign link_failure_flag_out = (q.st == RBX_ST_FAIL);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    a_frame_coded: assert property (
        link_tx_valid_out |-> frame_ok(link_tx_frame_out))
        else $error("outgoing frame not self-consistent");

    a_push_current: assert property (
        push |=> u_tx_fifo.q.count != '0)
        else $error("due frame not stored");

    a_send_tick: assert property (
        tick |=> q.pend ##0 (!tick) [*8])
        else $error("periodic send not requested");

    a_rx_update: assert property (
        (!link_failure_flag_out && good_ev) |=>
            rx_chan_out == $past(link_rx_frame_in.chan))
        else $error("good frame did not reach outputs");

    a_single_error: assert property (
        (!link_failure_flag_out && bad_ev && !fail_due)
            |=> !link_failure_flag_out)
        else $error("isolated error raised failure");

    a_fail_entry: assert property (
        (!link_failure_flag_out && bad_ev && fail_due)
            |=> link_failure_flag_out && $stable(rx_chan_out))
        else $error("repeated errors did not raise failure");

    a_recovery: assert property (
        (link_failure_flag_out && good_ev && recover_due)
            |=> !link_failure_flag_out
            && rx_chan_out == $past(link_rx_frame_in.chan))
        else $error("healthy frames did not restore operation");

    a_hold_fail: assert property (
        (link_failure_flag_out && !(good_ev && recover_due))
            |=> link_failure_flag_out && $stable(rx_chan_out))
        else $error("outputs moved while failed");

    a_bad_counts: assert property (
        (!link_failure_flag_out && bad_ev && !fail_due)
            |=> q.bad_cnt == run_next($past(q.bad_cnt)))
        else $error("bad frame not counted");

    a_run_restart: assert property (
        (!link_failure_flag_out && good_ev) |=> q.bad_cnt == 8'h00)
        else $error("good frame did not end the error run");

    a_silence_bad: assert property (
        (!link_failure_flag_out && timeout && q.bad_cnt == 8'h00
            && !fail_due) |=> q.bad_cnt == 8'h01)
        else $error("silent link not counted as bad frame");

    a_good_counts: assert property (
        (link_failure_flag_out && good_ev && !recover_due)
            |=> q.good_cnt == run_next($past(q.good_cnt)))
        else $error("healthy frame not counted while failed");

    a_fail_restart: assert property (
        (link_failure_flag_out && bad_ev) |=> q.good_cnt == 8'h00)
        else $error("bad frame did not end the healthy run");

    // the peer needs our frames to recover, so sending never stops
    a_fail_sends: assert property (
        (link_failure_flag_out && tick) |=> q.pend)
        else $error("send stopped while failed");

    a_pend_wait: assert property (
        (q.pend && !fifo_ready) |=> q.pend)
        else $error("due send dropped while buffer full");

    a_tx_stands: assert property (
        (link_tx_valid_out && !link_tx_ready_in)
            |=> link_tx_valid_out && $stable(link_tx_frame_out))
        else $error("outgoing frame changed before taken");

    // reset itself is checked with the default disable switched off
    a_reset_clean: assert property (disable iff (1'b0)
        !rst_n_in |=> !link_failure_flag_out && !link_tx_valid_out
            && rx_chan_out == RBX_CHAN_RST)
        else $error("reset left state behind");

    c_enter_fail: cover property (!link_failure_flag_out
        ##1 link_failure_flag_out);
    c_recover: cover property (link_failure_flag_out
        ##1 !link_failure_flag_out);
    c_tx_stall: cover property (q.pend && !fifo_ready);
    c_silence: cover property (timeout);

endmodule : rbx_link

`default_nettype wire

// ==== rbx_pkg.sv ====
/*
 Shared constants and types of the remote binary exchange: channel count,
 frame layout, link state codes, timing figures and failure thresholds.
 Assumes a single 50 MHz device clock.
*/
package rbx_pkg;

    // ------------------------------------------------------------
    // channels and timing
    // ------------------------------------------------------------
    localparam int RBX_CHANNELS = 16;
    localparam int RBX_CLK_NS = 20;
    localparam int RBX_SEND_NS = 20000;
    localparam int RBX_SEND_CYC = (RBX_SEND_NS + RBX_CLK_NS - 1) / RBX_CLK_NS;
    localparam int RBX_RX_TIMEOUT_NS = 100000;
    localparam int RBX_RX_TIMEOUT_CYC =
        (RBX_RX_TIMEOUT_NS + RBX_CLK_NS - 1) / RBX_CLK_NS;
    localparam int RBX_FAIL_COUNT = 3;
    localparam int RBX_RECOVER_COUNT = 3;
    localparam int RBX_FIFO_DEPTH = 4;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RBX_CHAN_RST = 16'h0000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [RBX_CHANNELS-1:0] chan;
        logic [RBX_CHANNELS-1:0] chan_n;
    } rbx_frame_t;

    localparam int RBX_FRAME_W = $bits(rbx_frame_t);

    typedef enum logic [1:0] {
        RBX_ST_RUN = 2'h1,
        RBX_ST_FAIL = 2'h2
    } rbx_state_t;

endpackage : rbx_pkg

// ==== rbx_fifo.sv ====
/*
 Small first-in first-out buffer with valid/ready on both sides.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module rbx_fifo
    import rbx_pkg::*;
#(
    parameter int WIDTH = RBX_FRAME_W,
    parameter int DEPTH = RBX_FIFO_DEPTH
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [CW-1:0] count;
    } rbx_fifo_state_t;

    rbx_fifo_state_t q, d;
    logic push, pop;

    function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
        next_ptr = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction : next_ptr

    assign in_ready_out = (q.count != CW'(DEPTH));
    assign out_valid_out = (q.count != '0);
    assign out_data_out = q.mem[q.rd_ptr];
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wr_ptr] = in_data_in;
            d.wr_ptr = next_ptr(q.wr_ptr);
        end
        if (pop) begin
            d.rd_ptr = next_ptr(q.rd_ptr);
        end
        if (push && !pop) begin
            d.count = q.count + CW'(1);
        end else if (pop && !push) begin
            d.count = q.count - CW'(1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_full_refuse: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (q.count == CW'(DEPTH) && !pop) |=> !in_ready_out)
        else $error("fifo accepted while full");

    c_fifo_full: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        !in_ready_out);

endmodule : rbx_fifo

`default_nettype wire

// ==== rbx_peer.sv ====
/*
 Far-end model of the remote binary exchange: takes and logs frames,
 sends good or broken frames on request.
 Assumes the bench calls send and drives ready at falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module rbx_peer
    import rbx_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic tx_valid_in,
    input wire rbx_frame_t tx_frame_in,
    output logic tx_ready_out,
    output logic rx_valid_out,
    output rbx_frame_t rx_frame_out,
    output logic rx_error_out
);
    rbx_frame_t got_q[$];
    int cyc_q[$];
    int cyc = 0;
    initial begin
        tx_ready_out = 1'b1;
        rx_valid_out = 1'b0;
        rx_frame_out = '0;
        rx_error_out = 1'b0;
    end
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (rst_n_in && tx_valid_in && tx_ready_out) begin
            got_q.push_back(tx_frame_in);
            cyc_q.push_back(cyc);
        end
    end
    // lets the bench stall and release the far end's intake
    task automatic set_ready(input logic r);
        tx_ready_out = r;
    endtask : set_ready
    // bad: 1 line error, 2 broken complement copy
    task automatic send(input logic [15:0] c, input int bad);
        @(negedge clk_in);
        rx_frame_out = {c, (bad == 2) ? c : ~c};
        rx_error_out = (bad == 1);
        rx_valid_out = 1'b1;
        @(negedge clk_in);
        rx_valid_out = 1'b0;
        rx_error_out = 1'b0;
        // released lines must not keep showing the frame
        rx_frame_out = ~rx_frame_out;
    endtask : send
endmodule : rbx_peer
`default_nettype wire

// ==== rbx_link_tb_top.sv ====
/*
 Self-checking bench of the remote binary exchange.
 Assumes rbx_peer as far end; short send and silence periods.
*/
`timescale 1ns/1ps
`default_nettype none
module rbx_link_tb_top
    import rbx_pkg::*;
;
    localparam int PER = 10;
    localparam int TMO = 60;
    logic clk_in, rst_n_in, tx_valid, tx_ready, rx_valid, rx_error, flag;
    logic [15:0] tx_chan, rx_chan;
    rbx_frame_t tx_frame, rx_frame;
    int n_fail = 0;
    int total_checks = 0;
    rbx_link #(
        .SEND_PERIOD_CYC(16'(PER)),
        .RX_TIMEOUT_CYC(16'(TMO)),
        .FAIL_COUNT(8'h03),
        .RECOVER_COUNT(8'h03),
        .FIFO_DEPTH(RBX_FIFO_DEPTH)
    ) uut (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .tx_chan_in(tx_chan),
        .rx_chan_out(rx_chan),
        .link_failure_flag_out(flag),
        .link_tx_valid_out(tx_valid),
        .link_tx_frame_out(tx_frame),
        .link_tx_ready_in(tx_ready),
        .link_rx_valid_in(rx_valid),
        .link_rx_frame_in(rx_frame),
        .link_rx_error_in(rx_error)
    );
    rbx_peer peer (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .tx_valid_in(tx_valid),
        .tx_frame_in(tx_frame),
        .tx_ready_out(tx_ready),
        .rx_valid_out(rx_valid),
        .rx_frame_out(rx_frame),
        .rx_error_out(rx_error)
    );
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    // ----------------------------------------
    // compares and closing
    // ----------------------------------------
    task automatic chk_chan(input logic [15:0] got, exp, input string s);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t %s got %h exp %h", $time, s, got, exp);
        end
    endtask : chk_chan
    task automatic chk_bit(input logic got, exp, input string s);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t %s got %b", $time, s, got);
        end
    endtask : chk_bit
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // checked one extra cycle on to stay clear of the update edge
    task automatic rx_step(input logic [15:0] c, input int bad,
            input logic [15:0] exp_rx, input logic exp_flag);
        peer.send(c, bad);
        @(negedge clk_in);
        chk_chan(rx_chan, exp_rx, "rx chan");
        chk_bit(flag, exp_flag, "fail flag");
    endtask : rx_step
    task automatic t_rx;
        rx_step(16'hA5C3, 0, 16'hA5C3, 1'b0);
        rx_step(16'h8001, 0, 16'h8001, 1'b0);
        rx_step(16'hDEAD, 1, 16'h8001, 1'b0);
        rx_step(16'h5678, 0, 16'h5678, 1'b0);
        rx_step(16'hBEEF, 2, 16'h5678, 1'b0);
        $display("test rx done");
    endtask : t_rx
    task automatic t_fail;
        rx_step(16'h0F0F, 0, 16'h0F0F, 1'b0);
        rx_step(16'hAAAA, 1, 16'h0F0F, 1'b0);
        rx_step(16'hAAAA, 2, 16'h0F0F, 1'b0);
        rx_step(16'hAAAA, 1, 16'h0F0F, 1'b1);
        rx_step(16'h1111, 0, 16'h0F0F, 1'b1);
        rx_step(16'h2222, 0, 16'h0F0F, 1'b1);
        rx_step(16'h3333, 2, 16'h0F0F, 1'b1);
        rx_step(16'h4444, 0, 16'h0F0F, 1'b1);
        rx_step(16'h5555, 0, 16'h0F0F, 1'b1);
        rx_step(16'h6666, 0, 16'h6666, 1'b0);
        $display("test fail done");
    endtask : t_fail
    // silence: each timeout counts as one bad frame
    task automatic t_silence;
        repeat (2 * TMO + 10) @(negedge clk_in);
        chk_bit(flag, 1'b0, "two timeouts");
        repeat (TMO) @(negedge clk_in);
        chk_bit(flag, 1'b1, "three timeouts");
        rx_step(16'h7777, 0, 16'h6666, 1'b1);
        rx_step(16'h7777, 0, 16'h6666, 1'b1);
        rx_step(16'h7777, 0, 16'h7777, 1'b0);
        $display("test silence done");
    endtask : t_silence
    task automatic get_frames(input int n);
        peer.got_q.delete();
        peer.cyc_q.delete();
        for (int i = 0; i < 10 * PER && peer.got_q.size() < n; i++) begin
            @(negedge clk_in);
        end
        if (peer.got_q.size() < n) begin
            n_fail++;
            $display("mismatch t=%0t frames missing", $time);
        end
    endtask : get_frames
    task automatic t_send;
        tx_chan = 16'hC33C;
        repeat (2 * PER) @(negedge clk_in);
        get_frames(2);
        chk_chan(peer.got_q[0].chan, 16'hC33C, "tx chan");
        chk_chan(peer.got_q[0].chan_n, 16'h3CC3, "tx copy");
        chk_chan(16'(peer.cyc_q[1] - peer.cyc_q[0]), 16'(PER), "gap");
        tx_chan = 16'h8001;
        repeat (2 * PER) @(negedge clk_in);
        get_frames(1);
        chk_chan(peer.got_q[0].chan, 16'h8001, "tx new");
        $display("test send done");
    endtask : t_send
    // stall far end until the fifo refuses, then drain
    task automatic t_fifo;
        tx_chan = 16'h0FF0;
        repeat (2 * PER) @(negedge clk_in);
        peer.set_ready(1'b0);
        repeat (6 * PER) @(negedge clk_in);
        chk_bit(tx_valid, 1'b1, "valid stands");
        chk_chan(tx_frame.chan, 16'h0FF0, "held frame");
        get_frames(0);
        peer.set_ready(1'b1);
        repeat (4) @(negedge clk_in);
        chk_bit(peer.got_q.size() >= 4, 1'b1, "drain");
        chk_chan(16'(peer.cyc_q[3] - peer.cyc_q[0]), 16'h0003, "b2b");
        chk_chan(peer.got_q[3].chan, 16'h0FF0, "drained");
        $display("test fifo done");
    endtask : t_fifo
    initial begin
        rst_n_in = 1'b0;
        tx_chan = 16'h0000;
        repeat (16) @(negedge clk_in);
        rst_n_in = 1'b1;
        @(negedge clk_in);
        chk_chan(rx_chan, RBX_CHAN_RST, "reset rx");
        chk_bit(flag, 1'b0, "reset flag");
        chk_bit(tx_valid, 1'b0, "reset valid");
        t_rx();
        t_fail();
        t_silence();
        t_send();
        t_fifo();
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        n_fail++;
        $display("mismatch t=%0t watchdog", $time);
        report_and_stop();
    end
endmodule : rbx_link_tb_top
`default_nettype wire
